// ### bench/btec_props.sv
// Checker for the tag error capture block, bound to btec_top.
// Assumes one clock domain and the synchronous reset of the top.
`timescale 1ns/10ps
`default_nettype none
module btec_props
   import btec_pkg::*;
#(
   parameter int TAG_USED = 12
)(
   input wire logic         clk_i,
   input wire logic         rst_i,
   input wire btec_lookup_t lookup_i,
   input wire logic         error_suppress_ctl_i,
   input wire logic         hw_error_transition_o,
   input wire btec_class_t  check_class_o,
   input wire logic         wb_cyc_i,
   input wire logic         wb_stb_i,
   input wire logic         wb_we_i,
   input wire logic [3:0]   wb_adr_i,
   input wire logic [31:0]  wb_dat_o,
   input wire logic         wb_ack_o
);
   // ****
   // Properties
   // ****
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic rd_take;
   // Read taken this edge; its data shows with the next ack
   assign rd_take = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

   ack_wait_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o) else $error("ack late");
   ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   pulse_cause_a: assert property (hw_error_transition_o
      |-> check_class_o[1] && $past(lookup_i.valid))
      else $error("pulse without cause");
   uncorrectable_flag_pulse_a: assert property (
      lookup_i.valid && !error_suppress_ctl_i ##1 check_class_o[1]
      |-> hw_error_transition_o) else $error("pulse missing");
   suppress_a: assert property (error_suppress_ctl_i
      |=> !hw_error_transition_o) else $error("pulse while suppressed");
   idle_class_a: assert property (!lookup_i.valid
      |=> check_class_o == BTEC_CL_NONE) else $error("class without lookup");
   addr_low_a: assert property (rd_take && wb_adr_i == 4'h4
      |=> wb_dat_o[4:0] == 5'h0) else $error("address low bits set");
   word_unused_a: assert property (rd_take && wb_adr_i == 4'h8
      |=> wb_dat_o[8:0] == 9'h0 && (wb_dat_o >> (17 + TAG_USED)) == 32'h0)
      else $error("unused tag word bits set");
   status_code_a: assert property (rd_take && wb_adr_i == 4'h0
      |=> wb_dat_o[31:10] == 22'h0 && wb_dat_o[9:5] inside
      {5'h00, 5'h07, 5'h03, 5'h02, 5'h08, 5'h0d, 5'h09, 5'h0a})
      else $error("status code or reserved bits wrong");
   cover property (check_class_o == BTEC_CL_CORRECTABLE_FLAG);
   cover property (check_class_o == BTEC_CL_ADDR);
   cover property (hw_error_transition_o);
endmodule

bind btec_top btec_props #(.TAG_USED(TAG_USED)) btec_props_inst (
   .clk_i(clk_i), .rst_i(rst_i), .lookup_i(lookup_i),
   .error_suppress_ctl_i(error_suppress_ctl_i),
   .hw_error_transition_o(hw_error_transition_o),
   .check_class_o(check_class_o), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
`default_nettype wire

// ### bench/btec_tagram.sv
// Tag RAM model: fills in check bits for a lookup and injects faults.
// Assumes the word layout and check bit sets of btec_map.svh.
`timescale 1ns/10ps
`default_nettype none
`include "btec_map.svh"
module btec_tagram
   import btec_pkg::*;
#(
   parameter int TAG_USED = 12
)(
   input  wire btec_lookup_t req_i,
   input  wire logic [1:0]   err_i,
   output btec_lookup_t      lookup_o
);
   // ****
   // Check bits
   // ****
   localparam logic [107:0] MASK = `BTEC_ECC_MASK;
   localparam logic [5:0]   ODD  = `BTEC_ECC_ODD;
   logic [17:0] vec;
   logic [5:0]  chk;
   // Kind 3 stores a wrong address parity, so the syndrome hits that column
   always_comb begin
      vec = {^req_i.addr ^ (err_i == 2'h3), req_i.word[1:0],
             req_i.word[22:8] & 15'((1 << TAG_USED) - 1)};
      for (int n = 0; n < 6; n++)
         chk[n] = ^(vec & MASK[18*n +: 18]) ^ ODD[n];
      // Kind 1 flips one check bit, kind 2 all six: matches no column
      if (err_i == 2'h1)
         chk[req_i.addr[1:0]] = ~chk[req_i.addr[1:0]];
      if (err_i == 2'h2)
         chk = ~chk;
      lookup_o = req_i;
      lookup_o.word[7:2] = chk;
      // Idle lines never keep the last value
      if (!req_i.valid) begin
         lookup_o.cmd = ~req_i.cmd;
         lookup_o.addr = ~req_i.addr;
         lookup_o.word = ~lookup_o.word;
      end
   end
endmodule
`default_nettype wire

// ### bench/btec_top_tb.sv
// Self-checking bench for btec_top behind a tag RAM model.
// Assumes package, map header and bound checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
   $display("wrong value at %0t: %h expected %h", $time, g, e); end end
module btec_top_tb
   import btec_pkg::*;
;
   localparam int TU = 12;
   logic         clk_i = 1'b0;
   logic         rst_i = 1'b1;
   btec_lookup_t req = '0;
   btec_lookup_t lookup_i;
   logic [1:0]   err_k = 2'h0;
   logic         sup = 1'b0;
   logic         hw_err;
   btec_class_t  cls;
   logic         cyc = 1'b0;
   logic         stb = 1'b0;
   logic         we = 1'b0;
   logic         ack;
   logic [3:0]   adr = 4'h0;
   logic [3:0]   sel = 4'h0;
   logic [31:0]  wdat = 32'h0;
   logic [31:0]  rdat;
   logic [31:0]  d;
   int           fail_count = 0;
   int           n_compared = 0;
   int           cycles = 0;
   btec_flags_t  ef = '0;
   logic [4:0]   ecmd = 5'h0;
   logic [31:0]  eaddr = 32'h0;
   logic [31:0]  eword = 32'h0;
   logic [4:0]   cmds [7] = '{5'h07, 5'h03, 5'h02, 5'h08, 5'h0d, 5'h09, 5'h0a};

   btec_tagram #(.TAG_USED(TU)) btec_tagram_inst (.req_i(req),
      .err_i(err_k), .lookup_o(lookup_i));
   btec_top #(.TAG_USED(TU)) btec_top_inst (.clk_i(clk_i), .rst_i(rst_i),
      .lookup_i(lookup_i), .error_suppress_ctl_i(sup),
      .hw_error_transition_o(hw_err), .check_class_o(cls), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));

   // ****
   // Clock, watchdog, tasks
   // ****
   initial begin
      forever #50 clk_i = ~clk_i;
   end
   // Run needs about 600 cycles; the ceiling leaves ample margin
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         fail_count++;
         final_report();
      end
   end
   task automatic final_report();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Classic cycle; ack is sampled on a rising edge, the request is held
   // until that edge, read data is taken there and only then released
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [31:0] v, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= v;
      sel <= s;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n == 50)
         fail_count++;
      d = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic chk_all();
      bus(1'b0, 4'h0, 32'h0, 4'hf);
      `CHK(d, {22'h0, ecmd, ef})
      bus(1'b0, 4'h4, 32'h0, 4'hf);
      `CHK(d, eaddr)
      bus(1'b0, 4'h8, 32'h0, 4'hf);
      `CHK(d, eword)
   endtask
   task automatic clr(input logic [31:0] m, input logic [3:0] s);
      bus(1'b1, 4'h0, m, s);
      if (s[0])
         ef = btec_flags_t'(ef & ~m[4:0]);
   endtask
   // One lookup; expected capture state follows the lock rules
   task automatic lk(input logic [4:0] c, input logic [1:0] e, input logic s);
      logic        ok;
      logic        cap;
      logic [22:0] w;
      ok = c inside {cmds};
      cap = ok && !s && e == 2'h1 && !ef.lock && !ef.correctable_flag;
      @(posedge clk_i);
      req <= '{1'b1, c, 27'($urandom), 23'($urandom)};
      err_k <= e;
      sup <= s;
      @(negedge clk_i);
      w = lookup_i.word;
      @(posedge clk_i);
      req.valid <= 1'b0;
      @(negedge clk_i);
      `CHK(hw_err, e[1] & ok & !s)
      if (!s)
         `CHK(cls, ok ? e : 2'h0)
      if (cap)
         ef.correctable_flag = 1'b1;
      if (ok && !s && e[1] && ef.lock)
         ef.lost = 1'b1;
      else if (ok && !s && e[1]) begin
         cap = 1'b1;
         ef.lock = 1'b1;
         ef.uncorrectable_flag |= !e[0];
         ef.addr |= e[0];
      end
      if (cap) begin
         ecmd = c;
         eaddr = {req.addr, 5'h0};
         eword = {w[22:8] & 15'((1 << TU) - 1), w[7:0], 9'h0};
      end
   endtask

   // ****
   // Main sequence
   // ****
   initial begin
      d = $urandom(32'hd685);
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      chk_all();
      bus(1'b0, 4'hc, 32'h0, 4'hf);
      `CHK(d, 32'h0)
      for (int i = 0; i < 7; i++) begin
         lk(cmds[i], 2'(i % 3 + 1), 1'b0);
         chk_all();
         clr(32'h1f, 4'hf);
      end
      lk(5'h07, 2'h1, 1'b0);
      lk(5'h03, 2'h1, 1'b0);
      chk_all();
      lk(5'h02, 2'h2, 1'b0);
      lk(5'h0d, 2'h3, 1'b0);
      lk(5'h09, 2'h2, 1'b0);
      lk(5'h0a, 2'h2, 1'b1);
      lk(5'h00, 2'h2, 1'b0);
      clr(32'h0, 4'hf);
      clr(32'h1f, 4'he);
      bus(1'b1, 4'h8, 32'hffffffff, 4'hf);
      bus(1'b1, 4'h4, 32'hffffffff, 4'hf);
      chk_all();
      clr(32'h1, 4'hf);
      lk(5'h08, 2'h2, 1'b0);
      chk_all();
      for (int i = 0; i < 80; i++) begin
         lk($urandom % 8 == 0 ? 5'h1f : cmds[$urandom % 7], 2'($urandom),
            $urandom % 8 == 0);
         if (i % 4 == 3) begin
            chk_all();
            clr($urandom % 2 ? 32'h1f : $urandom & 32'h1e, 4'hf);
         end
      end
      final_report();
   end
endmodule
`default_nettype wire

// ### hdl/btec_top.sv
// Tag store ECC check and error capture, with a Wishbone slave that
// exposes the status, address and tag word capture registers.
// Assumes lookups come from logic on clk_i and that the cache control
// register outside sets its transition bit from hw_error_transition_o.
//
// The implementer's own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
`include "btec_map.svh"

module btec_top
   import btec_pkg::*;
#(
   parameter int TAG_USED = `BTEC_TAG_USED
)(
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // Tag lookup path
   input  wire btec_lookup_t lookup_i,
   input  wire logic         error_suppress_ctl_i,
   output logic              hw_error_transition_o,
   output btec_class_t       check_class_o,
   // Wishbone slave
   input  wire logic         wb_cyc_i,
   input  wire logic         wb_stb_i,
   input  wire logic         wb_we_i,
   input  wire logic [3:0]   wb_adr_i,
   input  wire logic [3:0]   wb_sel_i,
   input  wire logic [31:0]  wb_dat_i,
   output logic [31:0]       wb_dat_o,
   output logic              wb_ack_o
);

   // *****************************************************************
   // Elaboration checks
   // *****************************************************************

   // The check bit input sets live in the map header only, so that the
   // generator in the tag RAM path and this checker can never drift
   // apart. Each row is one parity tree; each column is the syndrome
   // that a single flipped input produces.
   // Rows are C0 at index 0 up to C5 at index 5.
   // Columns 0 to 14 are the tag, 15 valid, 16 owned, 17 address parity.
   // A weak column (fewer than two ones) would look like a flipped
   // check bit and could not be told apart, so elaboration refuses it.
   // TAG_USED outside 1..15 would leave no tag or overrun the field.
   localparam logic [5:0][17:0] ECC_MASK = `BTEC_ECC_MASK;
   localparam logic [5:0]       ECC_ODD  = `BTEC_ECC_ODD;
   localparam int               NIN      = 18;

   // Column vectors of the matrix, one per protected input
   logic [5:0] col_w [NIN];

   genvar gi;
   genvar gj;
   generate
      if (TAG_USED < 1 || TAG_USED > 15) begin : g_bad_used
         $error("TAG_USED must lie in 1..15");
      end
      for (gi = 0; gi < NIN; gi++) begin : g_col
         for (gj = 0; gj < 6; gj++) begin : g_bit
            assign col_w[gi][gj] = ECC_MASK[gj][gi];
         end
         // A column with a single one would alias a check bit fault
         if ($countones({ECC_MASK[5][gi], ECC_MASK[4][gi],
                         ECC_MASK[3][gi], ECC_MASK[2][gi],
                         ECC_MASK[1][gi], ECC_MASK[0][gi]}) < 2)
         begin : g_weak
            $error("ECC column needs at least two ones");
         end
      end
   endgenerate

   // *****************************************************************
   // Syndrome and classification
   // *****************************************************************

   // The lookup is checked in the cycle it arrives; nothing here is
   // registered, so the class is known at the next edge together with
   // the capture decision. The price is one long path from the tag RAM
   // word through six parity trees and eighteen column compares.
   // Trade-off: a pipeline stage would shorten the path but would let a
   // clear and an error of adjacent cycles meet out of order.
   // Unused tag bits are masked before the trees as well as in the
   // captured word, so a smaller cache never sees phantom errors on
   // bits it does not store.
   logic [14:0]  tag_used_mask;
   logic [14:0]  tag_masked;
   logic         ap_w;
   logic [17:0]  ecc_in;
   logic [5:0]   stored_chk;
   logic [5:0]   gen_chk;
   logic [5:0]   syndrome;
   logic [NIN-1:0] col_hit;
   logic         chk_hit;
   logic         checked_cmd;
   btec_class_t  cls;
   logic [31:0]  word_fmt;

   // Unused tag bits forced low; they carry no meaning for this size
   assign tag_used_mask = 15'((32'h1 << TAG_USED) - 32'h1);
   assign tag_masked = lookup_i.word[22:8] & tag_used_mask;
   // Address parity is not stored; it is rebuilt from the request
   assign ap_w = ^lookup_i.addr;
   assign ecc_in = {ap_w, lookup_i.word[1], lookup_i.word[0],
                    tag_masked};
   assign stored_chk = lookup_i.word[7:2];

   // Parity trees, then syndrome against the stored check bits
   always_comb begin
      for (int k = 0; k < 6; k++) begin
         gen_chk[k] = (^(ECC_MASK[k] & ecc_in)) ^ ECC_ODD[k];
      end
      syndrome = gen_chk ^ stored_chk;
   end

   // Column match per protected input
   generate
      for (gi = 0; gi < NIN; gi++) begin : g_hit
         assign col_hit[gi] = (syndrome == col_w[gi]);
      end
   endgenerate

   // A lone syndrome bit means the stored check bit itself flipped
   assign chk_hit = ($countones(syndrome) == 1);

   // Only the seven lookup kinds are checked; fills and register
   // path tag accesses never reach the capture logic
   always_comb begin
      case (lookup_i.cmd)
         BTEC_CMD_DATA_READ_LOOKUP,
         BTEC_CMD_INSTR_READ_LOOKUP,
         BTEC_CMD_OWNERSHIP_READ_LOOKUP,
         BTEC_CMD_WREL,
         BTEC_CMD_RPROBE,
         BTEC_CMD_OPROBE,
         BTEC_CMD_EVICT: checked_cmd = 1'b1;
         default:        checked_cmd = 1'b0;
      endcase
   end

   // Classify; suppression makes every lookup look clean
   always_comb begin
      cls = BTEC_CL_NONE;
      if (!lookup_i.valid || !checked_cmd || error_suppress_ctl_i) begin
         cls = BTEC_CL_NONE;
      end else if (syndrome == 6'h00) begin
         cls = BTEC_CL_NONE;
      end else if (col_hit[`BTEC_AP_IDX]) begin
         cls = BTEC_CL_ADDR;
      end else if (chk_hit || (|col_hit)) begin
         cls = BTEC_CL_CORRECTABLE_FLAG;
      end else begin
         cls = BTEC_CL_UNCORRECTABLE_FLAG;
      end
   end

   // Captured word in register layout
   assign word_fmt = {tag_masked, stored_chk, lookup_i.word[1],
                      lookup_i.word[0], 9'h000};

   // *****************************************************************
   // Wishbone slave
   // *****************************************************************

   // Classic single cycle slave with exactly one wait state:
   //  edge 1 takes the request and snapshots the read data,
   //  edge 2 is where the master sees ack; writes act at that edge.
   // Ack drops by itself in the cycle after it was given, because the
   // next value is masked by the ack already standing.
   // Only the status register accepts writes, and only through byte
   // lane 0; the address and tag word registers ignore writes, and an
   // unmapped offset answers with zero data.
   // Limitation: no error or retry response; every request is acked.
   logic        ack_r;
   logic        ack_nxt;
   logic [31:0] rdat_r;
   logic [31:0] rdat_nxt;
   logic        wr_fire;
   logic [4:0]  clr_bits;
   btec_flags_t flags_r;
   logic [4:0]  cmd_r;
   logic [26:0] addr_r;
   logic [31:0] word_r;

   // Write acts at the edge where the master sees ack
   assign wr_fire = ack_r & wb_cyc_i & wb_stb_i & wb_we_i;
   assign clr_bits = (wr_fire && wb_sel_i[0] &&
                      wb_adr_i == `BTEC_OFF_STATUS) ?
                     wb_dat_i[4:0] : 5'h00;

   // One wait state: ack and read data register together
   always_comb begin
      ack_nxt  = wb_cyc_i & wb_stb_i & ~ack_r;
      rdat_nxt = 32'h0000_0000;
      if (wb_adr_i == `BTEC_OFF_STATUS) begin
         rdat_nxt = {22'h000000, cmd_r, flags_r};
      end else if (wb_adr_i == `BTEC_OFF_ADDRESS) begin
         rdat_nxt = {addr_r, 5'h00};
      end else if (wb_adr_i == `BTEC_OFF_WORD) begin
         rdat_nxt = word_r;
      end else begin
         rdat_nxt = 32'h0000_0000;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r  <= 1'b0;
         rdat_r <= 32'h0000_0000;
      end else begin
         ack_r  <= ack_nxt;
         rdat_r <= rdat_nxt;
      end
   end

   // *****************************************************************
   // Capture registers
   // *****************************************************************

   // Lock rules in short:
   //  - empty registers load on any error;
   //  - a captured correctable error blocks further correctables only;
   //  - an uncorrectable error reloads once and locks;
   //  - while locked, any uncorrectable error only sets lost.
   // The correctable flag is never cleared by hardware, so it stays set
   // when an uncorrectable error reloads the registers.
   // Hazard: a software clear and a new error in the same cycle. The
   // set wins, and a lock cleared in that cycle already counts as open,
   // so the new error is captured rather than lost.
   btec_flags_t flags_nxt;
   btec_flags_t clr_f;
   logic [4:0]  cmd_nxt;
   logic [26:0] addr_nxt;
   logic [31:0] word_nxt;
   logic        hwet_nxt;
   logic        hwet_r;
   btec_class_t cls_r;
   logic        lock_eff;
   logic        correctable_flag_eff;
   logic        is_unc;
   logic        load;

   assign clr_f = btec_flags_t'(clr_bits);
   // A lock cleared this very cycle already counts as unlocked, so an
   // error arriving with the clear is captured rather than lost
   assign lock_eff = flags_r.lock & ~clr_f.lock;
   assign correctable_flag_eff = flags_r.correctable_flag & ~clr_f.correctable_flag;
   assign is_unc = (cls == BTEC_CL_UNCORRECTABLE_FLAG) || (cls == BTEC_CL_ADDR);

   // Load decision and flag update; a set wins over a clear
   always_comb begin
      flags_nxt = btec_flags_t'(flags_r & ~clr_f);
      load      = 1'b0;
      hwet_nxt  = is_unc;
      if (cls == BTEC_CL_CORRECTABLE_FLAG) begin
         if (!correctable_flag_eff && !lock_eff) begin
            load           = 1'b1;
            flags_nxt.correctable_flag = 1'b1;
         end
      end else if (is_unc) begin
         if (lock_eff) begin
            flags_nxt.lost = 1'b1;
         end else begin
            load           = 1'b1;
            flags_nxt.lock = 1'b1;
            if (cls == BTEC_CL_ADDR) begin
               flags_nxt.addr = 1'b1;
            end else begin
               flags_nxt.uncorrectable_flag = 1'b1;
            end
         end
      end
      cmd_nxt  = load ? lookup_i.cmd : cmd_r;
      addr_nxt = load ? lookup_i.addr : addr_r;
      word_nxt = load ? word_fmt : word_r;
   end

   // Correctable_flag flag is never touched by the uncorrectable path above
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags_r <= btec_flags_t'(`BTEC_RST_FLAGS);
         cmd_r   <= `BTEC_RST_CMD;
         addr_r  <= 27'h0000000;
         word_r  <= `BTEC_RST_WORD;
         hwet_r  <= 1'b0;
         cls_r   <= BTEC_CL_NONE;
      end else begin
         flags_r <= flags_nxt;
         cmd_r   <= cmd_nxt;
         addr_r  <= addr_nxt;
         word_r  <= word_nxt;
         hwet_r  <= hwet_nxt;
         cls_r   <= cls;
      end
   end

   // *****************************************************************
   // Outputs
   // *****************************************************************

   // Every output is the plain output of a flip-flop, so nothing on the
   // far side sees a glitch from the parity trees or the decoders.
   // The transition request pulses once per uncorrectable lookup, even
   // while locked; the cache control register outside holds it.
   assign wb_ack_o              = ack_r;
   assign wb_dat_o              = rdat_r;
   assign hw_error_transition_o = hwet_r;
   assign check_class_o         = cls_r;

endmodule
`default_nettype wire

// ### pkg/btec_map.svh
// Offsets, field positions, reset values and ECC constants for the
// tag store error capture block. Definitions only; included by name.
`ifndef BTEC_MAP_SVH
`define BTEC_MAP_SVH

// Register byte offsets on the Wishbone slave
`define BTEC_OFF_STATUS   4'h0
`define BTEC_OFF_ADDRESS  4'h4
`define BTEC_OFF_WORD     4'h8

// Status field positions
`define BTEC_ST_LOCK      0
`define BTEC_ST_CORRECTABLE_FLAG      1
`define BTEC_ST_UNCORRECTABLE_FLAG    2
`define BTEC_ST_ADDR      3
`define BTEC_ST_LOST      4
`define BTEC_ST_CMD_LO    5
`define BTEC_ST_CMD_HI    9

// Tag word field positions
`define BTEC_TW_VALID     9
`define BTEC_TW_OWNED     10
`define BTEC_TW_ECC_LO    11
`define BTEC_TW_ECC_HI    16
`define BTEC_TW_TAG_LO    17
`define BTEC_TW_TAG_HI    31

// Address capture holds a hexaword address
`define BTEC_ADR_LO       5

// Reset values
`define BTEC_RST_FLAGS    5'h00
`define BTEC_RST_CMD      5'h00
`define BTEC_RST_WORD     32'h0000_0000

// Tag bits in use for the default cache size
`define BTEC_TAG_USED     12

// Check bit input sets: bits 14:0 tag, 15 valid, 16 owned, 17 parity
`define BTEC_ECC_MASK     {18'h07c00, 18'h043c0, 18'h32238, \
                           18'h29126, 18'h18895, 18'h3844b}
// Odd parity check bits (C1 and C4)
`define BTEC_ECC_ODD      6'h12
`define BTEC_AP_IDX       17

`endif

// ### pkg/btec_pkg.sv
// Types shared by the tag store error capture block.
// Assumes btec_map.svh is on the include path.
`default_nettype none
package btec_pkg;

   // Tag store operation codes that may report errors
   typedef enum logic [4:0] {
      BTEC_CMD_DATA_READ_LOOKUP   = 5'h07,
      BTEC_CMD_INSTR_READ_LOOKUP   = 5'h03,
      BTEC_CMD_OWNERSHIP_READ_LOOKUP   = 5'h02,
      BTEC_CMD_WREL    = 5'h08,
      BTEC_CMD_RPROBE  = 5'h0d,
      BTEC_CMD_OPROBE  = 5'h09,
      BTEC_CMD_EVICT   = 5'h0a
   } btec_cmd_t;

   // Outcome of one tag check
   typedef enum logic [1:0] {
      BTEC_CL_NONE   = 2'h0,
      BTEC_CL_CORRECTABLE_FLAG   = 2'h1,
      BTEC_CL_UNCORRECTABLE_FLAG = 2'h2,
      BTEC_CL_ADDR   = 2'h3
   } btec_class_t;

   // One tag lookup as seen by the checker
   typedef struct packed {
      logic        valid;
      logic [4:0]  cmd;
      logic [26:0] addr;
      logic [22:0] word;
   } btec_lookup_t;

   // Capture status flags
   typedef struct packed {
      logic lost;
      logic addr;
      logic uncorrectable_flag;
      logic correctable_flag;
      logic lock;
   } btec_flags_t;

endpackage
`default_nettype wire
